// >>> bench/rcs_far_model.sv
// display counter and character rom model facing the sequencer
// assumes strobes are active low and last at least two clocks
`timescale 1ns/1ps

module rcs_far_model #(
    parameter       DOTS     = 3,
    parameter [5:0] END_ADDR = 6'h0e
) (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       char_advance_n,
    input  wire       dot_step_n,
    output reg  [5:0] char_addr,
    output wire       last_dot_n,
    output wire       line_end_flag
);
    reg [4:0] dot_reg;   // dot position within the character
    reg       adv_d_reg; // delayed advance strobe
    reg       dot_d_reg; // delayed dot strobe
    // ==========================================
    // counters step one clock after a strobe falls, well inside 3 clocks
    always @(posedge ref_clk) begin
        adv_d_reg <= char_advance_n;
        dot_d_reg <= dot_step_n;
        if (!rst_n) begin
            char_addr <= 6'h00;
            dot_reg   <= 5'h00;
        end else if (adv_d_reg && !char_advance_n) begin
            char_addr <= char_addr + 6'h01; // wraps 63 to 0 as a 6-bit count
            dot_reg   <= 5'h00;
        end else if (dot_d_reg && !dot_step_n) begin
            dot_reg <= dot_reg + 5'h01;
        end
    end
    // flags stay put between strobes, so no stale value is hidden
    assign last_dot_n    = (dot_reg != DOTS - 1);
    assign line_end_flag = (char_addr == END_ADDR);
endmodule

// >>> bench/rcs_readout_seq_sva.sv
// checker for the readout character sequencer's ports
// assumes STATE_CYCLES is 8 and the far side settles within 3 clocks
`timescale 1ns/1ps

module rcs_readout_seq_sva #(
    parameter STATE_CYCLES = 8,
    parameter TICK_W       = 8
) (
    input wire       ref_clk,
    input wire       rst_n,
    input wire       clk_en,
    input wire       supply_settled,
    input wire       display_run,
    input wire       readout_start,
    input wire       last_dot_n,
    input wire       line_end_flag,
    input wire [5:0] char_addr,
    input wire       readout_beam_on_n,
    input wire       dot_step_n,
    input wire       char_advance_n,
    input wire [3:0] seq_state,
    input wire       seq_held
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // step tracking
    reg  [3:0] prev_reg; // state one clock earlier
    // hold pins mask the forced return to zero, which is not a step
    wire       step = (seq_state != prev_reg) && !seq_held && supply_settled && display_run;
    // previous state capture
    always @(posedge ref_clk) begin
        prev_reg <= seq_state;
    end
    // ==========================================
    // assertions
    AST_WAIT_START: assert property (step && prev_reg == 4'h1 |-> seq_state == 4'h2 && readout_start) else $error("state 1 left without start");
    AST_LOAD_THREE: assert property (step && prev_reg == 4'h2 |-> seq_state == 4'h3) else $error("state 2 did not load 3");
    AST_FIRST_SLOT: assert property (step && prev_reg == 4'h3 |-> seq_state == (char_addr == 6'h0b ? 4'h4 : 4'h2)) else $error("state 3 exit wrong");
    AST_SETTLE: assert property (step && prev_reg inside {4'h4, 4'h5, 4'hb} |-> seq_state == (prev_reg == 4'h5 ? 4'h6 : 4'h5)) else $error("settle path wrong");
    AST_DOT_TEST: assert property (step && prev_reg == 4'h6 |-> seq_state == (last_dot_n ? 4'h7 : 4'hd)) else $error("last dot test wrong");
    AST_DOT_RUN: assert property (step && prev_reg inside {[4'h7:4'ha]} |-> seq_state == prev_reg + 4'h1) else $error("dot run broken");
    AST_LINE_END: assert property (step && prev_reg == 4'hd |-> seq_state == (line_end_flag ? 4'he : 4'h4)) else $error("line end test wrong");
    AST_TAIL_LOAD: assert property (step && prev_reg == 4'he |-> seq_state == 4'hf) else $error("state e did not load f");
    AST_LAST_SLOT: assert property (step && prev_reg == 4'hf |-> seq_state == (char_addr == 6'h3f ? 4'h0 : 4'he)) else $error("state f exit wrong");
    AST_ZERO_ONE: assert property (step && prev_reg inside {4'h0, 4'hc} |-> seq_state == (prev_reg == 4'h0 ? 4'h1 : 4'h0)) else $error("state 0 or c exit wrong");
    AST_BEAM: assert property (readout_beam_on_n == !(seq_state inside {4'h8, 4'h9, 4'ha})) else $error("beam strobe wrong");
    AST_DOT_STB: assert property (dot_step_n == (seq_state != 4'hb)) else $error("dot step strobe wrong");
    AST_CHAR_STB: assert property (char_advance_n == !(seq_state inside {4'h3, 4'hd, 4'hf})) else $error("char advance strobe wrong");
    AST_HOLD: assert property (!supply_settled || !display_run |-> ##[1:5] (seq_held && seq_state == 4'h0 && readout_beam_on_n && dot_step_n && char_advance_n)) else $error("hold not taken");
    AST_STATE_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n || !supply_settled || !display_run) step |=> $stable(seq_state) [*7]) else $error("state shorter than one period");
    // ==========================================
    // scenario covers
    COV_LINE_END: cover property (step && prev_reg == 4'hd && seq_state == 4'he);
    COV_BEAM: cover property (step && seq_state == 4'h8);
    COV_HOLD: cover property ($rose(seq_held));
endmodule

bind rcs_readout_seq rcs_readout_seq_sva #(.STATE_CYCLES(STATE_CYCLES), .TICK_W(TICK_W))
    rcs_readout_seq_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .supply_settled(supply_settled), .display_run(display_run), .readout_start(readout_start),
    .last_dot_n(last_dot_n), .line_end_flag(line_end_flag), .char_addr(char_addr),
    .readout_beam_on_n(readout_beam_on_n), .dot_step_n(dot_step_n),
    .char_advance_n(char_advance_n), .seq_state(seq_state), .seq_held(seq_held));

// >>> bench/test_readout_char_sequencer.sv
// self-checking bench for the readout character sequencer
// assumes the far side model and the bound checker are compiled first
`timescale 1ns/1ps

module test_readout_char_sequencer;
    localparam       SC       = 8;     // clocks per state
    localparam       DOTS     = 3;     // dot slots per character
    localparam       CHARS    = 3;     // characters from slot 11 to line end
    localparam [5:0] END_ADDR = 6'h0e; // slot that raises the line end flag
    reg        ref_clk = 1'b0;
    reg        rst_n = 1'b0;
    reg        supply_settled = 1'b0;
    reg        display_run = 1'b0;
    reg        readout_start = 1'b0;
    reg        clk_en = 1'b1;
    wire [5:0] char_addr;
    wire       last_dot_n, line_end_flag, readout_beam_on_n, dot_step_n, char_advance_n;
    wire [3:0] seq_state;
    wire       seq_held;
    integer    err_total = 0, check_count = 0;
    integer    adv_cnt = 0, beam_cnt = 0, dot_cnt = 0, beam_len = 0;
    reg        beam_d = 1'b1, dot_d = 1'b1, adv_d = 1'b1;

    // ==========================================
    // clock and units
    always #12.5 ref_clk = ~ref_clk;
    rcs_readout_seq #(.STATE_CYCLES(SC), .TICK_W(8)) rcs_readout_seq_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .supply_settled(supply_settled),
        .display_run(display_run), .readout_start(readout_start), .last_dot_n(last_dot_n),
        .line_end_flag(line_end_flag), .char_addr(char_addr),
        .readout_beam_on_n(readout_beam_on_n), .dot_step_n(dot_step_n),
        .char_advance_n(char_advance_n), .seq_state(seq_state), .seq_held(seq_held));
    rcs_far_model #(.DOTS(DOTS), .END_ADDR(END_ADDR)) rcs_far_model_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .char_advance_n(char_advance_n),
        .dot_step_n(dot_step_n), .char_addr(char_addr), .last_dot_n(last_dot_n),
        .line_end_flag(line_end_flag));

    // ==========================================
    // shared helpers
    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // bounded wait; a line takes well under 4000 clocks
    task wait_state(input [3:0] want);
        integer n;
        begin
            n = 0;
            while (seq_state !== want && n < 4000) begin
                @(negedge ref_clk);
                n = n + 1;
            end
            check(n < 4000, 1);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    // ==========================================
    // strobe monitor, sampled mid-cycle away from launching edges
    always @(negedge ref_clk) begin
        if (beam_d && !readout_beam_on_n) beam_cnt = beam_cnt + 1;
        if (dot_d && !dot_step_n) dot_cnt = dot_cnt + 1;
        if (adv_d && !char_advance_n) adv_cnt = adv_cnt + 1;
        if (!readout_beam_on_n) beam_len = beam_len + 1;
        else if (beam_len != 0) begin
            check(beam_len, 3 * SC);
            beam_len = 0;
        end
        beam_d = readout_beam_on_n;
        dot_d  = dot_step_n;
        adv_d  = char_advance_n;
    end

    // ==========================================
    // scenarios
    task check_held;
        begin
            check({seq_held, seq_state, readout_beam_on_n, dot_step_n, char_advance_n}, 8'h87);
        end
    endtask
    // power and run rise, no start: must park in state 1
    task check_wait;
        begin
            @(posedge ref_clk);
            supply_settled <= 1'b1;
            display_run    <= 1'b1;
            repeat (60) @(negedge ref_clk);
            check({seq_held, seq_state}, 5'h01);
            check(adv_cnt, 0);
            // a frozen clock enable must not see a start request
            @(posedge ref_clk);
            clk_en        <= 1'b0;
            readout_start <= 1'b1;
            repeat (40) @(negedge ref_clk);
            check(seq_state, 4'h1);
            @(posedge ref_clk);
            clk_en        <= 1'b1;
            readout_start <= 1'b0;
            repeat (20) @(negedge ref_clk);
            check({seq_held, seq_state}, 5'h01);
            check(adv_cnt, 0);
        end
    endtask
    // one full line; exp_adv depends on where the counter starts
    task check_line(input [31:0] exp_adv);
        begin
            adv_cnt  = 0;
            beam_cnt = 0;
            dot_cnt  = 0;
            @(posedge ref_clk);
            readout_start <= 1'b1;
            wait_state(4'h2);
            @(posedge ref_clk);
            readout_start <= 1'b0;
            wait_state(4'h4);
            check(char_addr, 6'h0b);
            wait_state(4'he);
            wait_state(4'h0);
            check(adv_cnt, exp_adv);
            check(beam_cnt, CHARS * (DOTS - 1));
            check(dot_cnt, CHARS * (DOTS - 1));
            check(char_addr, 6'h3f);
            wait_state(4'h1);
        end
    endtask
    // drop power, then run, mid-line; both must force the idle state
    task check_hold;
        integer i;
        begin
            for (i = 0; i < 2; i = i + 1) begin
                @(posedge ref_clk);
                readout_start <= 1'b1;
                wait_state(i ? 4'h3 : 4'h6);
                @(posedge ref_clk);
                readout_start <= 1'b0;
                if (i == 0) supply_settled <= 1'b0;
                else display_run <= 1'b0;
                repeat (12) @(negedge ref_clk);
                check_held;
                @(posedge ref_clk);
                supply_settled <= 1'b1;
                display_run    <= 1'b1;
                wait_state(4'h1);
            end
        end
    endtask

    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check_held;
        check_wait;
        check_line(63);
        check_line(64);
        check_hold;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total = err_total + 1;
        conclude;
    end
endmodule

// >>> rtl/rcs_defines.vh
// constants shared by the readout character sequencer files
// assumes a 40 MHz ref_clk; the sequencer steps at a 5 MHz rate
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// ==========================================
// timing
`define RCS_REF_MHZ        40
`define RCS_STATE_NS       200
`define RCS_STATE_CYCLES   ((`RCS_STATE_NS * `RCS_REF_MHZ + 999) / 1000)
`define RCS_BEAM_NS        600

// ==========================================
// rom word fields
`define RCS_ROM_NEXT_MSB   7
`define RCS_ROM_NEXT_LSB   4
`define RCS_ROM_SEL_MSB    3
`define RCS_ROM_SEL_LSB    1
`define RCS_ROM_FIXED      0

// ==========================================
// condition selects
`define RCS_SEL_START      3'h0
`define RCS_SEL_FIRST      3'h2
`define RCS_SEL_LASTDOT    3'h3
`define RCS_SEL_LINEEND    3'h4
`define RCS_SEL_LINELAST   3'h5

// ==========================================
// strobe word bits and idle value
`define RCS_STB_BEAM       2
`define RCS_STB_DOT        1
`define RCS_STB_CHAR       0
`define RCS_STB_IDLE       3'h7

// ==========================================
// display counter addresses and reset values
`define RCS_ADDR_FIRST     6'h0b
`define RCS_ADDR_LAST      6'h3f
`define RCS_STATE_RST      4'h0

`endif

// >>> rtl/rcs_readout_seq.v
// rom-driven sequencer that draws one readout line of dot characters
// assumes the display counter and the character rom sit outside and
// answer the step strobes within three ref_clk cycles
`timescale 1ns/1ps
`include "rcs_defines.vh"

module rcs_readout_seq #(
    parameter STATE_CYCLES = `RCS_STATE_CYCLES,
    parameter TICK_W       = 8
) (
    input  wire       ref_clk,
    input  wire       rst_n,
    input  wire       clk_en,
    input  wire       supply_settled,
    input  wire       display_run,
    input  wire       readout_start,
    input  wire       last_dot_n,
    input  wire       line_end_flag,
    input  wire [5:0] char_addr,
    output reg        readout_beam_on_n,
    output reg        dot_step_n,
    output reg        char_advance_n,
    output reg  [3:0] seq_state,
    output reg        seq_held
);

    // ==========================================
    // state codes
    localparam [3:0] ST_IDLE     = 4'h0;  // parked, strobes idle
    localparam [3:0] ST_WAIT     = 4'h1;  // waiting for start request
    localparam [3:0] ST_SKIP_LO  = 4'h2;  // release char strobe in skip
    localparam [3:0] ST_SKIP_HI  = 4'h3;  // step counter toward slot 11
    localparam [3:0] ST_CHAR     = 4'h4;  // start of a character
    localparam [3:0] ST_SETTLE   = 4'h5;  // deflection settling delay
    localparam [3:0] ST_DOTTEST  = 4'h6;  // test for last dot
    localparam [3:0] ST_DOTGO    = 4'h7;  // not last dot, go draw
    localparam [3:0] ST_BEAM0    = 4'h8;  // beam on, first period
    localparam [3:0] ST_BEAM1    = 4'h9;  // beam on, second period
    localparam [3:0] ST_BEAM2    = 4'ha;  // beam on, third period
    localparam [3:0] ST_DOTSTEP  = 4'hb;  // advance dot counter
    localparam [3:0] ST_SPARE    = 4'hc;  // unused code
    localparam [3:0] ST_NEXTCHAR = 4'hd;  // step counter, test line end
    localparam [3:0] ST_TAIL_LO  = 4'he;  // release char strobe in tail
    localparam [3:0] ST_TAIL_HI  = 4'hf;  // step counter toward slot 63

    // ==========================================
    // sequence rom: {next[3:0], select[2:0], fixed}
    function [7:0] rom_word;
        input [3:0] st;
        begin
            case (st)
                // state 0 always loads 1
                ST_IDLE:     rom_word = {ST_WAIT, 3'h0, 1'b1};
                // a held test reloads 1
                ST_WAIT:     rom_word = {ST_WAIT, `RCS_SEL_START, 1'b0};
                ST_SKIP_LO:  rom_word = {ST_SKIP_HI, 3'h0, 1'b1};
                // missing address 11 returns to 2
                ST_SKIP_HI:  rom_word = {ST_SKIP_LO, `RCS_SEL_FIRST, 1'b0};
                ST_CHAR:     rom_word = {ST_SETTLE, 3'h0, 1'b1};
                ST_SETTLE:   rom_word = {ST_DOTTEST, 3'h0, 1'b1};
                // last dot loads D, otherwise count to 7
                ST_DOTTEST:  rom_word = {ST_NEXTCHAR, `RCS_SEL_LASTDOT, 1'b0};
                ST_DOTGO:    rom_word = {ST_BEAM0, 3'h0, 1'b1};
                ST_BEAM0:    rom_word = {ST_BEAM1, 3'h0, 1'b1};
                ST_BEAM1:    rom_word = {ST_BEAM2, 3'h0, 1'b1};
                ST_BEAM2:    rom_word = {ST_DOTSTEP, 3'h0, 1'b1};
                ST_DOTSTEP:  rom_word = {ST_SETTLE, 3'h0, 1'b1};
                // line not ended reloads 4
                ST_NEXTCHAR: rom_word = {ST_CHAR, `RCS_SEL_LINEEND, 1'b0};
                ST_TAIL_LO:  rom_word = {ST_TAIL_HI, 3'h0, 1'b1};
                // missing address 63 returns to E
                ST_TAIL_HI:  rom_word = {ST_TAIL_LO, `RCS_SEL_LINELAST, 1'b0};
                // spare code parks the sequencer
                default:     rom_word = {ST_IDLE, 3'h0, 1'b1};
            endcase
        end
    endfunction

    // ==========================================
    // strobe rom: {beam_n, dot_n, char_n}, all active low
    function [2:0] strobe_word;
        input [3:0] st;
        begin
            case (st)
                ST_SKIP_HI:  strobe_word = 3'h6;
                ST_BEAM0:    strobe_word = 3'h3;
                ST_BEAM1:    strobe_word = 3'h3;
                ST_BEAM2:    strobe_word = 3'h3;
                ST_DOTSTEP:  strobe_word = 3'h5;
                ST_NEXTCHAR: strobe_word = 3'h6;
                ST_TAIL_HI:  strobe_word = 3'h6;
                // state 0, the release states and spares stay idle
                default:     strobe_word = `RCS_STB_IDLE;
            endcase
        end
    endfunction

    // ==========================================
    // display counter address compare, used for both skip targets
    function addr_match;
        input [5:0] addr;
        input [5:0] target;
        begin
            addr_match = (addr == target);
        end
    endfunction

    // ==========================================
    // synchronised pins
    wire [10:0] pins_sync;       // all pin inputs after three stages
    wire       settled_s;        // supply settled
    wire       run_s;            // display run
    wire       start_s;          // readout start request
    wire       last_dot_n_s;     // last dot of character, active low
    wire       line_end_s;       // end of readout line
    wire [5:0] addr_s;           // display counter low address bits
    wire       tick;             // one-cycle 5 MHz step enable

    // every pin comes from outside logic, so all share one chain
    // five single levels plus the six address bits make eleven
    rcs_sync #(
        .WIDTH (11)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .async_in ({supply_settled, display_run, readout_start,
                    last_dot_n, line_end_flag, char_addr}),
        .sync_out (pins_sync)
    );

    assign settled_s    = pins_sync[10];
    assign run_s        = pins_sync[9];
    assign start_s      = pins_sync[8];
    assign last_dot_n_s = pins_sync[7];
    assign line_end_s   = pins_sync[6];
    assign addr_s       = pins_sync[5:0] & 6'h3f;

    // ==========================================
    // hold and step timing
    wire hold;                   // sequencer forced to state 0

    // either power or the display run level low holds state 0
    assign hold = ~(settled_s & run_s);

    // the divider restarts under hold so state 0 lasts a full period
    rcs_tick #(
        .DIV   (STATE_CYCLES),
        .CNT_W (TICK_W)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .clear   (hold),
        .tick    (tick)
    );

    // ==========================================
    // state register and decision
    reg  [3:0] state_reg;        // current sequence state
    reg  [3:0] state_next;       // state after the next step
    reg  [7:0] word;             // rom word of the current state
    reg        cond;             // selected condition level
    reg  [4:0] incr;             // incremented state, carry kept apart

    // pick the condition named by the select field
    always @* begin
        word = rom_word(state_reg);
        case (word[`RCS_ROM_SEL_MSB:`RCS_ROM_SEL_LSB])
            `RCS_SEL_START:    cond = start_s;
            // slot 11 is the first shown character on each line
            `RCS_SEL_FIRST:    cond = addr_match(addr_s, `RCS_ADDR_FIRST);
            `RCS_SEL_LASTDOT:  cond = last_dot_n_s;
            `RCS_SEL_LINEEND:  cond = line_end_s;
            `RCS_SEL_LINELAST: cond = addr_match(addr_s, `RCS_ADDR_LAST);
            // unwired selector inputs read low, which forces a load
            default:           cond = 1'b0;
        endcase
    end

    // fixed states load; decision states count on a true test
    always @* begin
        incr = {1'b0, state_reg} + 5'h01;
        if (word[`RCS_ROM_FIXED]) begin
            // fixed bit high disables the test entirely
            state_next = word[`RCS_ROM_NEXT_MSB:`RCS_ROM_NEXT_LSB];
        end else if (cond) begin
            // true test increments: 1->2, 3->4, 6->7, D->E, F->0
            state_next = incr[3:0];
        end else begin
            // false test parallel-loads the rom next state
            state_next = word[`RCS_ROM_NEXT_MSB:`RCS_ROM_NEXT_LSB];
        end
    end

    // ==========================================
    // state update; the 2/3 and E/F loops fall out of the rom table
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= `RCS_STATE_RST;
        end else if (clk_en) begin
            if (hold) begin
                // held at zero as long as either level is low
                state_reg <= `RCS_STATE_RST;
            end else if (tick) begin
                // one step per 5 MHz period; 200 ns per state
                state_reg <= state_next;
            end
        end
    end

    // ==========================================
    // registered outputs
    // strobes are looked up from the state being entered so that
    // each pin changes in the same ref_clk edge as the state
    reg [2:0] stb_next;          // strobe pattern for the next cycle
    reg [3:0] state_out_next;    // state shown on seq_state

    always @* begin
        if (hold) begin
            stb_next       = `RCS_STB_IDLE;
            state_out_next = `RCS_STATE_RST;
        end else if (tick) begin
            stb_next       = strobe_word(state_next);
            state_out_next = state_next;
        end else begin
            stb_next       = strobe_word(state_reg);
            state_out_next = state_reg;
        end
    end

    // output flops; each strobe lasts whole state periods, three for the beam, unless hold ends it early
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            readout_beam_on_n <= 1'b1;
            dot_step_n        <= 1'b1;
            char_advance_n    <= 1'b1;
            seq_state         <= `RCS_STATE_RST;
            seq_held          <= 1'b1;
        end else if (clk_en) begin
            readout_beam_on_n <= stb_next[`RCS_STB_BEAM];
            dot_step_n        <= stb_next[`RCS_STB_DOT];
            char_advance_n    <= stb_next[`RCS_STB_CHAR];
            seq_state         <= state_out_next;
            seq_held          <= hold;
        end
    end

endmodule

// >>> rtl/rcs_sync.v
// three-stage input synchroniser for asynchronous levels
// assumes inputs come from outside ref_clk's domain
`timescale 1ns/1ps
`include "rcs_defines.vh"

module rcs_sync #(
    parameter WIDTH = 10
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire             clk_en,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1_reg;  // first stage, read only by stage2
    reg [WIDTH-1:0] stage2_reg;  // second stage
    reg [WIDTH-1:0] stage3_reg;  // third stage

    // ==========================================
    // shift chain; a bit is accepted once stages two and three agree
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
            stage3_reg <= {WIDTH{1'b0}};
            sync_out   <= {WIDTH{1'b0}};
        end else if (clk_en) begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // per-bit agreement filters a single-cycle disagreement
            sync_out   <= (stage2_reg & stage3_reg) | (sync_out & (stage2_reg | stage3_reg));
        end
    end

endmodule

// >>> rtl/rcs_tick.v
// divider producing the one-cycle state-step enable
// assumes clear restarts the period so the first state is full length
`timescale 1ns/1ps
`include "rcs_defines.vh"

module rcs_tick #(
    parameter DIV   = 8,
    parameter CNT_W = 8
) (
    input  wire ref_clk,
    input  wire rst_n,
    input  wire clk_en,
    input  wire clear,
    output reg  tick
);

    localparam integer     LAST_I = DIV - 1;            // terminal count, full width
    localparam [CNT_W-1:0] LAST   = LAST_I[CNT_W-1:0];  // terminal count, cut to counter

    reg [CNT_W-1:0] cnt_reg;  // ref_clk cycles within one state period

    // ==========================================
    // count ref_clk cycles; pulse tick for one cycle per period
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= {CNT_W{1'b0}};
            tick    <= 1'b0;
        end else if (clk_en) begin
            if (clear) begin
                cnt_reg <= {CNT_W{1'b0}};
                tick    <= 1'b0;
            end else if (cnt_reg == LAST) begin
                cnt_reg <= {CNT_W{1'b0}};
                tick    <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                tick    <= 1'b0;
            end
        end
    end

endmodule
